// >>> pkg/ocbl_map.vh
// register offsets, field positions and reset values of the list pointer bank
`ifndef OCBL_MAP_VH
`define OCBL_MAP_VH
`define OCBL_CTRL_HEAD_OFS 8'h20
`define OCBL_CTRL_CUR_OFS 8'h24
`define OCBL_BULK_HEAD_OFS 8'h28
`define OCBL_PTR_RESET 32'h00000000
`define OCBL_ADDR_MSB 31
`define OCBL_ADDR_LSB 4
`define OCBL_RSVD_MSB 3
`define OCBL_RSVD_LSB 0
`define OCBL_LIST_FILLED_BIT 1
`define OCBL_CTRL_ENABLE_BIT 4
`endif

// >>> rtl/ocbl_ptr_reg.v
// one 32-bit descriptor pointer register with reserved low nibble
`timescale 1ns/1ps
`include "ocbl_map.vh"
module ocbl_ptr_reg #(
  parameter AW = 28
) (
  input wire clock, // core clock
  input wire rst_n, // async reset, active low
  input wire load, // load strobe
  input wire [AW-1:0] din, // new address field
  output reg [31:0] q // register value
);
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= `OCBL_PTR_RESET;
    end else if (load) begin
      q <= {din, 4'h0};
    end
  end
endmodule // ocbl_ptr_reg

// >>> rtl/ocbl_list_pointers.v
// control and bulk endpoint list pointer registers with control list walker
`timescale 1ns/1ps
`include "ocbl_map.vh"
module ocbl_list_pointers #(
  parameter AW = 28
) (
  input wire clock, // core clock, 100 MHz
  input wire rst_n, // async reset, active low
  input wire reg_wr, // register write strobe
  input wire reg_rd, // register read strobe
  input wire [7:0] reg_addr, // register byte offset
  input wire [31:0] reg_wdata, // register write data
  input wire init_load, // init: load heads from shared area
  input wire [31:0] init_ctrl_head, // control head word from shared area
  input wire [31:0] init_bulk_head, // bulk head word from shared area
  input wire control_list_enable, // control list enable bit
  input wire frame_start, // start of frame pulse
  input wire ed_served, // control descriptor served pulse
  input wire [31:0] ed_next_link, // next link of the served descriptor
  input wire control_list_filled_flag, // filled flag in command status
  output reg [31:0] reg_rdata, // read data, valid after reg_rd
  output reg reg_rvalid, // read data valid pulse
  output reg clear_list_filled, // pulse: clear the filled flag
  output reg [31:0] control_walk_address, // descriptor to fetch next
  output reg control_walk_active, // control list has a descriptor to serve
  output reg [31:0] bulk_walk_start // bulk walk start address
);
  wire [31:0] control_list_head_pointer;
  wire [31:0] control_list_current_pointer;
  wire [31:0] bulk_list_head_pointer;
  reg ch_load;
  reg [AW-1:0] ch_din;
  reg cc_load;
  reg [AW-1:0] cc_din;
  reg bh_load;
  reg [AW-1:0] bh_din;
  reg next_clear;
  reg [31:0] next_rdata;
  wire wr_bulk_head;
  wire wr_ctrl_cur;
  wire ctrl_cur_zero;
  wire next_link_zero;
  wire served_live;
  wire served_end_reload;
  wire frame_end_reload;
  wire cur_write_ok;

  // address field of a pointer word, reserved nibble dropped
  function [AW-1:0] addr_field;
    input [31:0] w;
    begin
      addr_field = w[`OCBL_ADDR_MSB:`OCBL_ADDR_LSB];
    end
  endfunction

  // a pointer word whose address field is zero marks the end of a list
  function field_zero;
    input [31:0] w;
    begin
      field_zero = (addr_field(w) == {AW{1'b0}});
    end
  endfunction

  // bus offset decode, shared by the write strobes and the read mux
  function reg_hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      reg_hit = (a == ofs);
    end
  endfunction

  // control head, read-only on the bus
  ocbl_ptr_reg #(
    .AW(AW)
  ) u_ctrl_head (
    .clock(clock),
    .rst_n(rst_n),
    .load(ch_load),
    .din(ch_din),
    .q(control_list_head_pointer)
  );

  ocbl_ptr_reg #(
    .AW(AW)
  ) u_ctrl_cur (
    .clock(clock),
    .rst_n(rst_n),
    .load(cc_load),
    .din(cc_din),
    .q(control_list_current_pointer)
  );

  ocbl_ptr_reg #(
    .AW(AW)
  ) u_bulk_head (
    .clock(clock),
    .rst_n(rst_n),
    .load(bh_load),
    .din(bh_din),
    .q(bulk_list_head_pointer)
  );

  // decoded write strobes
  assign wr_bulk_head = reg_wr && reg_hit(reg_addr, `OCBL_BULK_HEAD_OFS);
  assign wr_ctrl_cur = reg_wr && reg_hit(reg_addr, `OCBL_CTRL_CUR_OFS);

  assign ctrl_cur_zero = field_zero(control_list_current_pointer);
  assign next_link_zero = field_zero(ed_next_link);

  // a served descriptor only counts while the list still has one
  assign served_live = ed_served && !ctrl_cur_zero;
  assign served_end_reload = served_live && next_link_zero && control_list_filled_flag;
  // reload at frame start once the previous pass ran off the end
  assign frame_end_reload = !served_live && frame_start && ctrl_cur_zero
                            && control_list_filled_flag;
  // write only while disabled, and the walker goes first
  assign cur_write_ok = !served_live && !frame_end_reload && wr_ctrl_cur
                        && !control_list_enable;

  always @* begin
    ch_load = init_load;
    ch_din = addr_field(init_ctrl_head);
    bh_load = init_load || wr_bulk_head;
    bh_din = addr_field(reg_wdata);
    if (init_load) begin
      bh_din = addr_field(init_bulk_head);
    end
  end

  // current pointer: walker events first, then the bus
  always @* begin
    cc_load = 1'b0;
    cc_din = addr_field(reg_wdata);
    next_clear = 1'b0;
    if (served_live) begin
      cc_load = 1'b1;
      cc_din = addr_field(ed_next_link);
    end
    if (served_end_reload || frame_end_reload) begin
      cc_load = 1'b1;
      cc_din = addr_field(control_list_head_pointer);
      next_clear = 1'b1;
    end
    if (cur_write_ok) begin
      cc_load = 1'b1;
    end
  end

  // read mux; unmapped offsets read zero
  always @* begin
    next_rdata = 32'h00000000;
    if (reg_hit(reg_addr, `OCBL_CTRL_HEAD_OFS)) begin
      next_rdata = control_list_head_pointer;
    end
    if (reg_hit(reg_addr, `OCBL_CTRL_CUR_OFS)) begin
      next_rdata = control_list_current_pointer;
    end
    if (reg_hit(reg_addr, `OCBL_BULK_HEAD_OFS)) begin
      next_rdata = bulk_list_head_pointer;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `OCBL_PTR_RESET;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // flag clear request, one cycle after the reload
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clear_list_filled <= 1'b0;
    end else begin
      clear_list_filled <= next_clear;
    end
  end

  // walk follows the current pointer; head enters it only by reload
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      control_walk_address <= `OCBL_PTR_RESET;
      control_walk_active <= 1'b0;
    end else begin
      control_walk_address <= control_list_current_pointer;
      control_walk_active <= control_list_enable && !ctrl_cur_zero;
    end
  end

  // bulk walk start follows the bulk head
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bulk_walk_start <= `OCBL_PTR_RESET;
    end else begin
      bulk_walk_start <= bulk_list_head_pointer;
    end
  end
endmodule // ocbl_list_pointers

// >>> verification/ocbl_chk_sva.sv
// port assertions for the list pointer bank
`timescale 1ns/1ps
module ocbl_chk (
  input wire clock, rst_n, reg_wr, reg_rd, init_load, control_list_enable, frame_start,
  input wire ed_served, control_list_filled_flag, reg_rvalid, clear_list_filled,
  input wire control_walk_active,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata, ed_next_link, reg_rdata, control_walk_address, bulk_walk_start
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_rv; reg_rd |=> reg_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("read lost");
  property p_nib; reg_rvalid |-> reg_rdata[3:0] == 4'h0; endproperty
  a_nib: assert property (p_nib) else $error("low bits set");
  property p_bulk; reg_wr && reg_addr == 8'h28 && !init_load |=> ##1
    bulk_walk_start == {$past(reg_wdata[31:4], 2), 4'h0}; endproperty
  a_bulk: assert property (p_bulk) else $error("bulk head wrong");
  property p_clr; clear_list_filled |-> $past(control_list_filled_flag); endproperty
  a_clr: assert property (p_clr) else $error("clear without flag");
  property p_act; control_walk_active |-> $past(control_list_enable) && control_walk_address != 0;
  endproperty
  a_act: assert property (p_act) else $error("walk active at list end");
  property p_adv; ed_served && ed_next_link[31:4] != 0 ##1 control_walk_address != 0 |=>
    control_walk_address == {$past(ed_next_link[31:4], 2), 4'h0}; endproperty
  a_adv: assert property (p_adv) else $error("no advance");
  property p_frm; frame_start && !ed_served && !reg_wr && !control_list_filled_flag |=> ##1
    $stable(control_walk_address); endproperty
  a_frm: assert property (p_frm) else $error("frame moved pointer");
  property p_lock; reg_wr && reg_addr == 8'h24 && control_list_enable && !ed_served && !frame_start
    |=> ##1 $stable(control_walk_address); endproperty
  a_lock: assert property (p_lock) else $error("locked write taken");
endmodule // ocbl_chk
bind ocbl_list_pointers ocbl_chk u_chk (.clock, .rst_n, .reg_wr, .reg_rd, .init_load,
  .control_list_enable, .frame_start, .ed_served, .control_list_filled_flag, .reg_rvalid,
  .clear_list_filled, .control_walk_active, .reg_addr, .reg_wdata, .ed_next_link, .reg_rdata,
  .control_walk_address, .bulk_walk_start);

// >>> verification/tb_top.sv
// self-checking bench for the list pointer bank
`timescale 1ns/1ps
module tb_top;
  reg clock = 0, rst_n = 0, reg_wr, reg_rd, init_load, control_list_enable, frame_start;
  reg ed_served, control_list_filled_flag;
  reg [7:0] reg_addr;
  reg [31:0] reg_wdata, init_ctrl_head, init_bulk_head, ed_next_link, d, h, b, e;
  wire [31:0] reg_rdata, control_walk_address, bulk_walk_start;
  wire reg_rvalid, clear_list_filled, control_walk_active;
  integer seed = 32'hd9749ee4, error_cnt = 0, checks = 0;
  logic [31:0] q[$];
  logic [31:0] cq[$];
  always #5 clock = ~clock;
  ocbl_list_pointers u_dut (.clock, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .init_load,
    .init_ctrl_head, .init_bulk_head, .control_list_enable, .frame_start, .ed_served,
    .ed_next_link, .control_list_filled_flag, .reg_rdata, .reg_rvalid, .clear_list_filled,
    .control_walk_address, .control_walk_active, .bulk_walk_start);
  task chk(input [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chk_clr(input [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t clear at %h exp %h", $time, got, exp);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    @(posedge clock) reg_rd <= 1;
    reg_addr <= a;
    q.push_back(e);
    @(posedge clock) reg_rd <= 0;
  endtask
  task wr(input [7:0] a, input [31:0] v);
    @(posedge clock) reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock) reg_wr <= 0;
  endtask
  task p(input [2:0] s, input [31:0] l);
    @(posedge clock) {init_load, ed_served, frame_start} <= s;
    ed_next_link <= l;
    @(posedge clock) {init_load, ed_served, frame_start} <= 3'h0;
  endtask
  task close_out;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // read results come back in request order
  always @(posedge clock) if (reg_rvalid === 1'b1) chk(reg_rdata, q.pop_front());
  // a clear pulse shows the pointer that was current when the list ended
  always @(posedge clock) if (clear_list_filled === 1'b1) begin
    e = cq.size() ? cq.pop_front() : ~control_walk_address;
    chk_clr(control_walk_address, e);
  end
  initial begin
    #200000 error_cnt++;
    close_out;
  end
  initial begin
    {reg_wr, reg_rd, init_load, ed_served, frame_start, control_list_enable} <= 6'h0;
    {control_list_filled_flag, reg_addr, reg_wdata, ed_next_link} <= 0;
    d = $random(seed) | 32'h10;
    h = $random(seed) | 32'h10;
    b = $random(seed) | 32'h10;
    init_ctrl_head <= h;
    init_bulk_head <= b;
    repeat (20) @(posedge clock);
    rst_n <= 1;
    rd(8'h20, 0);
    rd(8'h24, 0);
    wr(8'h28, {d[31:4], 4'h0});
    rd(8'h28, {d[31:4], 4'h0});
    wr(8'h20, d);
    rd(8'h20, 0);
    rd(8'h30, 0);
    $display("test registers done");
    p(3'h4, 0);
    rd(8'h20, {h[31:4], 4'h0});
    rd(8'h28, {b[31:4], 4'h0});
    wr(8'h24, d);
    control_list_enable <= 1;
    wr(8'h24, h);
    rd(8'h24, {d[31:4], 4'h0});
    p(3'h2, b);
    p(3'h1, 0);
    rd(8'h24, {b[31:4], 4'h0});
    control_list_filled_flag <= 1;
    cq.push_back({b[31:4], 4'h0});
    p(3'h2, 0);
    control_list_filled_flag <= 0;
    rd(8'h24, {h[31:4], 4'h0});
    p(3'h2, 0);
    rd(8'h24, 0);
    p(3'h2, b);
    rd(8'h24, 0);
    control_list_filled_flag <= 1;
    cq.push_back(0);
    p(3'h1, 0);
    control_list_filled_flag <= 0;
    rd(8'h24, {h[31:4], 4'h0});
    $display("test walker done");
    repeat (3) @(posedge clock);
    chk_clr(cq.size(), 0);
    close_out;
  end
endmodule // tb_top
